// ==== common/idpr_defs.svh ====
// Register offsets, field positions and reset values of the identify responder.
`ifndef IDPR_DEFS_SVH
`define IDPR_DEFS_SVH
`define IDPR_OFF_CMD     8'h00
`define IDPR_OFF_DATA    8'h04
`define IDPR_OFF_GEOM    8'h08
`define IDPR_OFF_CGEOM   8'h0C
`define IDPR_OFF_CAP     8'h10
`define IDPR_OFF_LBA     8'h14
`define IDPR_OFF_MODE    8'h18
`define IDPR_OFF_MULT    8'h1C
`define IDPR_OFF_FLAG    8'h20
`define IDPR_OFF_LONG    8'h24
`define IDPR_CMD_GO      0
`define IDPR_ST_BUSY     0
`define IDPR_ST_REQ      1
`define IDPR_ST_IRQ      2
`define IDPR_W0_ATAPI    15
`define IDPR_W0_REMOV    7
`define IDPR_W0_FIXED    6
`define IDPR_W49_STBY    13
`define IDPR_W49_IORDY   11
`define IDPR_W49_IODIS   10
`define IDPR_W59_MVALID  8
`define IDPR_LAST_WORD   8'hFF
`define IDPR_RST_GEOM    32'h0000_0000
`define IDPR_RST_MODE    32'h0000_0000
`define IDPR_RST_MULT    32'h0000_0000
`define IDPR_RST_FLAG    32'h0000_0000
`define IDPR_RST_LONG    16'h0000
`endif

// ==== common/idpr_pkg.sv ====
// Types shared by the identify responder files.
package idpr_pkg;
    typedef enum logic [1:0] {IDPR_IDLE, IDPR_FILL, IDPR_XFER} idpr_state_e;
    typedef logic [15:0] idpr_word_t;
endpackage

// ==== src/idpr_str_word.sv ====
// Picks one two-character word out of a fixed ASCII string.
`timescale 1ns/1ns
`default_nettype none
module idpr_str_word import idpr_pkg::*; #(
    parameter int                  CHARS = 40,
    parameter logic [7:0]          BASE  = 8'h0A,
    parameter logic [CHARS*8-1:0]  TEXT  = '0
) (
    input  wire logic [7:0] idx,
    output idpr_word_t      word
);
    logic [7:0] k;

    always_comb begin
        k    = idx - BASE;
        word = '0;
        if (idx >= BASE && k < 8'(CHARS / 2)) begin
            word = TEXT[CHARS*8-1-16*k -: 16];
        end
    end
endmodule
`default_nettype wire

// ==== src/idpr_sector_buf.sv ====
// Sector buffer with one write port and one registered read port.
`timescale 1ns/1ns
`default_nettype none
module idpr_sector_buf import idpr_pkg::*; #(
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire idpr_word_t    wdata,
    input  wire logic [AW-1:0] raddr,
    output idpr_word_t         rdata
);
    idpr_word_t mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ==== src/idpr_responder.sv ====
// Identify-command responder with APB registers and a sector buffer.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "idpr_defs.svh"
`default_nettype none
// Behaviour
// - Command: busy, fill buffer, then request, interrupt.
// - Reserved bits and words read zero.
// - Word 0 holds class, removable, fixed.
// - Words 1, 3, 6 hold default geometry.
// - Serial, firmware, model strings in ASCII.
// - Word 21 gives buffer size.
// - Word 22 gives long-command extra bytes.
// - Word 47 gives maximum multiple sectors.
// - Word 49 holds standby and IORDY capabilities.
// - Words 51, 52 carry modes in upper byte.
// - Word 53 holds validity flags.
// - Words 54-58 give current geometry, capacity.
// - Word 59 holds multiple setting and valid.
// - Words 60-61 give LBA sector count.
// - Word 63 upper byte: active multiword mode.
// - Word 64 low byte: advanced PIO modes.
// - Words 65-68 give cycle times.
// - Word 80 claims ATA-4 and ATA-3.
// - Word 80 claims ATA-2 and ATA-1.
// - Word 88 reports Ultra DMA modes.
module idpr_responder import idpr_pkg::*; #(
    // Identity strings below are arbitrary values.
    parameter logic [159:0] SERIAL     = "SERIAL01234567890123",
    parameter logic [63:0]  FIRMWARE   = "REV00001",
    parameter logic [319:0] MODEL      = "MODEL-0123456789012345678901234567890123",
    parameter idpr_word_t   T_MDMA_MIN = 16'h0078,
    parameter idpr_word_t   T_MDMA_REC = 16'h0078,
    parameter idpr_word_t   T_PIO_MIN  = 16'h0078,
    parameter idpr_word_t   T_PIO_RDY  = 16'h0078
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy_flag,
    output logic             data_request_flag,
    output logic             intrq
);
    idpr_state_e state_r;
    logic [7:0]  fill_idx_r;
    logic [7:0]  rd_ptr_r;
    logic        irq_r;
    logic [31:0] geom_r;
    logic [31:0] cgeom_r;
    logic [31:0] cap_r;
    logic [31:0] lba_r;
    logic [31:0] mode_r;
    logic [31:0] mult_r;
    logic [31:0] flag_r;
    logic [15:0] long_r;
    idpr_word_t  tw;
    idpr_word_t  buf_q;
    idpr_word_t  ser_w;
    idpr_word_t  fw_w;
    idpr_word_t  mod_w;
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic        start;
    logic        rd_data;
    logic        fill_we;
    logic        fill_end;
    logic        st_rd;

    assign acc      = psel && penable;
    assign wr_acc   = acc && pwrite;
    assign rd_acc   = acc && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = acc && !hit;
    assign start    = wr_acc && paddr == `IDPR_OFF_CMD && pwdata[`IDPR_CMD_GO]
                      && state_r == IDPR_IDLE;
    assign rd_data  = rd_acc && paddr == `IDPR_OFF_DATA && state_r == IDPR_XFER;
    assign st_rd    = rd_acc && paddr == `IDPR_OFF_CMD;
    assign fill_we  = state_r == IDPR_FILL;
    assign fill_end = fill_we && fill_idx_r == `IDPR_LAST_WORD;
    assign busy_flag         = state_r == IDPR_FILL;
    assign data_request_flag = state_r == IDPR_XFER;
    assign intrq             = irq_r;

    always_comb begin
        case (paddr)
            `IDPR_OFF_CMD, `IDPR_OFF_DATA, `IDPR_OFF_GEOM, `IDPR_OFF_CGEOM,
            `IDPR_OFF_CAP, `IDPR_OFF_LBA, `IDPR_OFF_MODE, `IDPR_OFF_MULT,
            `IDPR_OFF_FLAG, `IDPR_OFF_LONG: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        prdata = '0;
        case (paddr)
            `IDPR_OFF_CMD: begin
                prdata[`IDPR_ST_BUSY] = busy_flag;
                prdata[`IDPR_ST_REQ]  = data_request_flag;
                prdata[`IDPR_ST_IRQ]  = irq_r;
            end
            `IDPR_OFF_DATA:  prdata = data_request_flag ? {16'h0000, buf_q} : '0;
            `IDPR_OFF_GEOM:  prdata = geom_r;
            `IDPR_OFF_CGEOM: prdata = cgeom_r;
            `IDPR_OFF_CAP:   prdata = cap_r;
            `IDPR_OFF_LBA:   prdata = lba_r;
            `IDPR_OFF_MODE:  prdata = mode_r;
            `IDPR_OFF_MULT:  prdata = mult_r;
            `IDPR_OFF_FLAG:  prdata = flag_r;
            `IDPR_OFF_LONG:  prdata = {16'h0000, long_r};
            default:         prdata = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            geom_r  <= `IDPR_RST_GEOM;
            cgeom_r <= `IDPR_RST_GEOM;
            cap_r   <= `IDPR_RST_GEOM;
            lba_r   <= `IDPR_RST_GEOM;
            mode_r  <= `IDPR_RST_MODE;
            mult_r  <= `IDPR_RST_MULT;
            flag_r  <= `IDPR_RST_FLAG;
            long_r  <= `IDPR_RST_LONG;
        end else if (wr_acc) begin
            case (paddr)
                `IDPR_OFF_GEOM:  geom_r  <= pwdata;
                `IDPR_OFF_CGEOM: cgeom_r <= pwdata;
                `IDPR_OFF_CAP:   cap_r   <= pwdata;
                `IDPR_OFF_LBA:   lba_r   <= pwdata;
                `IDPR_OFF_MODE:  mode_r  <= pwdata;
                `IDPR_OFF_MULT:  mult_r  <= pwdata;
                `IDPR_OFF_FLAG:  flag_r  <= pwdata;
                `IDPR_OFF_LONG:  long_r  <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= IDPR_IDLE;
        end else begin
            case (state_r)
                IDPR_IDLE: if (start) state_r <= IDPR_FILL;
                IDPR_FILL: if (fill_end) state_r <= IDPR_XFER;
                IDPR_XFER: if (rd_data && rd_ptr_r == `IDPR_LAST_WORD) state_r <= IDPR_IDLE;
                default:   state_r <= IDPR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || start) begin
            fill_idx_r <= '0;
        end else if (fill_we) begin
            fill_idx_r <= fill_idx_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || start) begin
            rd_ptr_r <= '0;
        end else if (rd_data) begin
            rd_ptr_r <= rd_ptr_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else if (fill_end) begin
            irq_r <= 1'b1;
        end else if (st_rd || start) begin
            irq_r <= 1'b0;
        end
    end

    idpr_str_word #(.CHARS(20), .BASE(8'h0A), .TEXT(SERIAL)) u_ser (
        .idx  (fill_idx_r),
        .word (ser_w)
    );
    idpr_str_word #(.CHARS(8), .BASE(8'h17), .TEXT(FIRMWARE)) u_fw (
        .idx  (fill_idx_r),
        .word (fw_w)
    );
    idpr_str_word #(.CHARS(40), .BASE(8'h1B), .TEXT(MODEL)) u_mod (
        .idx  (fill_idx_r),
        .word (mod_w)
    );

    always_comb begin
        tw = '0;
        case (fill_idx_r)
            8'h00: begin
                tw[`IDPR_W0_ATAPI] = flag_r[0];
                tw[`IDPR_W0_REMOV] = flag_r[1];
                tw[`IDPR_W0_FIXED] = flag_r[2];
            end
            8'h01: tw = geom_r[15:0];
            8'h03: tw = {8'h00, geom_r[23:16]};
            8'h06: tw = {8'h00, geom_r[31:24]};
            8'h15: tw = flag_r[31:16];
            8'h16: tw = long_r;
            8'h2F: tw = {8'h00, mult_r[7:0]};
            8'h31: begin
                tw[`IDPR_W49_STBY]  = flag_r[3];
                tw[`IDPR_W49_IORDY] = flag_r[4];
                tw[`IDPR_W49_IODIS] = flag_r[5];
            end
            8'h33: tw = {mode_r[7:0], 8'h00};
            8'h34: tw = {mode_r[15:8], 8'h00};
            8'h35: tw = {13'h0000, flag_r[8:6]};
            8'h36: tw = cgeom_r[15:0];
            8'h37: tw = {8'h00, cgeom_r[23:16]};
            8'h38: tw = {8'h00, cgeom_r[31:24]};
            8'h39: tw = cap_r[15:0];
            8'h3A: tw = cap_r[31:16];
            8'h3B: tw = {7'h00, mult_r[16], mult_r[15:8]};
            8'h3C: tw = lba_r[15:0];
            8'h3D: tw = lba_r[31:16];
            8'h3F: tw = {mode_r[23:16], 8'h00};
            8'h40: tw = {8'h00, mode_r[31:24]};
            8'h41: tw = T_MDMA_MIN;
            8'h42: tw = T_MDMA_REC;
            8'h43: tw = T_PIO_MIN;
            8'h44: tw = T_PIO_RDY;
            8'h50: tw = {11'h000, flag_r[12:9], 1'b0};
            8'h58: tw = {5'h00, mult_r[19:17], 5'h00, mult_r[22:20]};
            default: tw = ser_w | fw_w | mod_w;
        endcase
    end

    idpr_sector_buf #(.AW(8)) u_buf (
        .clk   (clk),
        .rstn  (rstn),
        .we    (fill_we),
        .waddr (fill_idx_r),
        .wdata (tw),
        .raddr (rd_ptr_r),
        .rdata (buf_q)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    cmd_to_req_a: assert property (start |=> busy_flag ##256
        (!busy_flag && data_request_flag && intrq))
        else $error("identify sequence out of order");
    req_after_busy_a: assert property ($rose(data_request_flag) |->
        $past(busy_flag) && intrq)
        else $error("request without prior busy");
    rsv_words_a: assert property (fill_we && fill_idx_r inside
        {8'h02, 8'h04, 8'h05, 8'h07, 8'h14, 8'h30, 8'h32, 8'h3E, 8'h45, 8'h4F} |-> tw == '0)
        else $error("reserved word not zero");
    word_zero_a: assert property (fill_we && fill_idx_r == 8'h00 |->
        tw[14:8] == '0 && tw[5:0] == '0 && tw[15] == flag_r[0])
        else $error("configuration word wrong");
    str_order_a: assert property (fill_we && fill_idx_r == 8'h0A |->
        tw == SERIAL[159:144])
        else $error("string byte order wrong");
    mode_low_a: assert property (fill_we && fill_idx_r inside {8'h33, 8'h34} |->
        tw[7:0] == 8'h00)
        else $error("mode word low byte not zero");
    mult_word_a: assert property (fill_we && fill_idx_r == 8'h3B |->
        tw[15:9] == '0 && tw[8] == mult_r[16])
        else $error("multiple setting word wrong");
    ver_word_a: assert property (fill_we && fill_idx_r == 8'h50 |->
        tw[15:5] == '0 && !tw[0])
        else $error("version word reserved bits set");
    udma_word_a: assert property (fill_we && fill_idx_r == 8'h58 |->
        tw[15:11] == '0 && tw[7:3] == '0)
        else $error("ultra dma reserved bits set");
    req_drop_a: assert property (rd_data && rd_ptr_r == 8'hFF |=>
        !data_request_flag)
        else $error("request held after last word");
    irq_set_a: assert property (fill_end |=> intrq)
        else $error("interrupt not raised after fill");
    flags_excl_a: assert property (!(busy_flag && data_request_flag))
        else $error("busy and request both set");
    first_word_a: assert property ($rose(data_request_flag) |->
        rd_ptr_r == 8'h00)
        else $error("transfer not starting at word zero");
    no_advance_a: assert property (rd_acc && !data_request_flag |=>
        $stable(rd_ptr_r))
        else $error("data pointer moved outside transfer");
    geom_word_a: assert property (fill_we && fill_idx_r == 8'h01 |->
        tw == geom_r[15:0])
        else $error("cylinder word wrong");
    buf_size_a: assert property (fill_we && fill_idx_r == 8'h15 |->
        tw == flag_r[31:16])
        else $error("buffer size word wrong");
    long_word_a: assert property (fill_we && fill_idx_r == 8'h16 |->
        tw == long_r)
        else $error("long command word wrong");

    start_c: cover property (start);
    req_c: cover property ($rose(data_request_flag));
    busy_c: cover property ($fell(busy_flag));
    last_c: cover property (rd_data && rd_ptr_r == 8'hFF);
    err_c: cover property (pslverr);
endmodule
`default_nettype wire

// ==== tb/idpr_host.sv ====
// Host model: an APB master that reads the identify table out of the responder.
`timescale 1ns/1ns
`default_nettype none
module idpr_host import idpr_pkg::*; (
    input  wire logic        clk,
    input  wire logic        data_req,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer, held until pready is seen high at a rising edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : ~pwdata;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic read_table(output idpr_word_t tab [256], output int n);
        logic [31:0] q;
        logic        e;
        n = 0;
        while (n < 300) begin
            @(posedge clk);
            if (data_req !== 1'b1) break;
            xfer(1'b0, 8'h04, 32'h0000_0000, q, e);
            if (n < 256) tab[n] = q[15:0];
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/test_identify_parameter_responder.sv ====
// Self-checking bench for the identify responder driven through the host model.
`timescale 1ns/1ns
`default_nettype none
module test_identify_parameter_responder import idpr_pkg::*;;
    typedef struct {logic [7:0] w; idpr_word_t v;} idpr_row_s;
    localparam logic [159:0] SER = "SN0123456789ABCDEFGH";
    localparam logic [319:0] MOD = "md-abcdefghijklmnopqrstuvwxyz0123456789.";
    localparam logic [63:0]  FW  = "FW1.2.3a";
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, busy, data_req, intrq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n;
    idpr_word_t  exp_tab [256];
    idpr_word_t  got [256];
    logic [31:0] cfg [10] = '{32'h0, 32'h0, 32'h3F10_1234, 32'h2A0F_0ABC, 32'h0123_4567,
                              32'h89AB_CDEF, 32'h0302_0104, 32'h0079_0810, 32'h0040_155B,
                              32'h0000_0004};
    idpr_row_s   rows [27] = '{
        '{8'h00, 16'h8080}, '{8'h01, 16'h1234}, '{8'h03, 16'h0010},
        '{8'h06, 16'h003F}, '{8'h15, 16'h0040}, '{8'h16, 16'h0004},
        '{8'h2F, 16'h0010}, '{8'h31, 16'h2800}, '{8'h33, 16'h0400},
        '{8'h34, 16'h0100}, '{8'h35, 16'h0005}, '{8'h36, 16'h0ABC},
        '{8'h37, 16'h000F}, '{8'h38, 16'h002A}, '{8'h39, 16'h4567},
        '{8'h3A, 16'h0123}, '{8'h3B, 16'h0108}, '{8'h3C, 16'hCDEF},
        '{8'h3D, 16'h89AB}, '{8'h3F, 16'h0200}, '{8'h40, 16'h0003},
        '{8'h41, 16'h0078}, '{8'h42, 16'h0078}, '{8'h43, 16'h0078},
        '{8'h44, 16'h0078}, '{8'h50, 16'h0014}, '{8'h58, 16'h0407}
    };

    idpr_responder #(.SERIAL(SER), .FIRMWARE(FW), .MODEL(MOD)) idpr_responder_i (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy_flag(busy), .data_request_flag(data_req), .intrq(intrq));

    idpr_host idpr_host_i (
        .clk(clk), .data_req(data_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    always #50 clk = ~clk;

    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            conclude();
        end
    end

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] q;
        logic        err;
        idpr_host_i.xfer(1'b0, a, 32'h0000_0000, q, err);
        cmp("read data", e, q);
        cmp("read error", {31'h0, ee}, {31'h0, err});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        err;
        idpr_host_i.xfer(1'b1, a, d, q, err);
    endtask

    // Counts edges until the request flag rises, checking busy meanwhile.
    task automatic wait_req(output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
            if (data_req !== 1'b1) cmp("busy while filling", 1, busy);
        end while (data_req !== 1'b1 && k < 400);
    endtask

    initial begin
        for (int i = 0; i < 256; i++) exp_tab[i] = 16'h0000;
        for (int i = 0; i < 20; i++) begin
            if (i < 10) exp_tab[10+i] = SER[159-16*i -: 16];
            exp_tab[27+i] = MOD[319-16*i -: 16];
            if (i < 4) exp_tab[23+i] = FW[63-16*i -: 16];
        end
        foreach (rows[r]) exp_tab[rows[r].w] = rows[r].v;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp("busy after reset", 0, busy);
        cmp("request after reset", 0, data_req);
        cmp("ready after reset", 1, pready);
        cmp("error after reset", 0, pslverr);
        cmp("interrupt after reset", 0, intrq);
        rd(8'h04, 32'h0, 1'b0);
        rd(8'hFC, 32'h0, 1'b1);
        for (int i = 2; i < 10; i++) wr(8'(4*i), cfg[i]);
        wr(8'h00, 32'h1);
        wait_req(n);
        cmp("fill cycles", 256, n);
        cmp("busy at request", 0, busy);
        cmp("interrupt at request", 1, intrq);
        rd(8'h00, 32'h6, 1'b0);
        rd(8'h00, 32'h2, 1'b0);
        idpr_host_i.read_table(got, n);
        cmp("words read", 256, n);
        for (int i = 0; i < 256; i++) cmp("table word", exp_tab[i], got[i]);
        rd(8'h04, 32'h0, 1'b0);
        wr(8'h20, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h1);
        wait_req(n);
        cmp("fill cycles after repeat", 253, n);
        idpr_host_i.read_table(got, n);
        cmp("words read again", 256, n);
        cmp("class word", 0, got[0]);
        cmp("capability word", 0, got[49]);
        cmp("version word", 0, got[80]);
        cmp("interrupt before restart", 1, intrq);
        wr(8'h00, 32'h1);
        #1;
        cmp("interrupt cleared by start", 0, intrq);
        repeat (3) @(posedge clk);
        cmp("busy before second reset", 1, busy);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp("busy after second reset", 0, busy);
        cmp("request after second reset", 0, data_req);
        cmp("interrupt after second reset", 0, intrq);
        rd(8'h08, 32'h0, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
